//--- design/clk_ctrl_pkg.sv
// constants and helpers shared by the pll and pwm clock control block
package clk_ctrl_pkg;

  // apb address decode
  localparam int ADDR_W = 12;
  localparam logic [11:0] RUN_MODE_CLOCK_CONFIG_OFFSET = 12'h060;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h070;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h074;
  localparam logic [11:0] CLOCK_STATE_OFFSET = 12'h078;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  // field positions inside the run-mode clock configuration register
  localparam int PWM_DIV_MSB = 19;
  localparam int PWM_DIV_LSB = 17;
  localparam int RSVD_MSB = 16;
  localparam int RSVD_LSB = 14;
  localparam int PWR_DOWN_BIT = 13;
  localparam int OUT_EN_N_BIT = 12;
  localparam int BYPASS_BIT = 11;
  localparam int VERIFY_BIT = 10;
  localparam int OSC_MSB = 5;
  localparam int OSC_LSB = 4;

  // reset values of the implemented fields
  localparam logic [2:0] PWM_DIV_RESET = 3'h7;
  localparam logic [2:0] RSVD_RESET = 3'h0;
  localparam logic PWR_DOWN_RESET = 1'b1;
  localparam logic OUT_EN_N_RESET = 1'b1;
  localparam logic BYPASS_RESET = 1'b1;
  localparam logic VERIFY_RESET = 1'b0;
  localparam logic [1:0] OSC_RESET = 2'h0;

  // oscillator source codes
  localparam logic [1:0] OSC_MAIN = 2'h0;
  localparam logic [1:0] OSC_INTERNAL = 2'h1;
  localparam logic [1:0] OSC_INTERNAL_DIV4 = 2'h2;
  localparam logic [1:0] OSC_RESERVED = 2'h3;

  // interrupt status and mask layout
  localparam int IRQ_W = 2;
  localparam int IRQ_PLL_FAIL_BIT = 0;
  localparam int IRQ_PLL_RECOVER_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // live clock state layout
  localparam int STATE_PLL_RUNNING = 0;
  localparam int STATE_VERIFY_ACTIVE = 1;
  localparam int STATE_PLL_FAILED = 2;
  localparam int STATE_ADC_USABLE = 3;

  // pwm divider counter: widest division is by 64
  localparam int PWM_CNT_W = 6;
  localparam logic [2:0] PWM_TAP_MAX = 3'h5;

  // verification timer timing
  localparam int SYS_CLK_MHZ = 200;
  localparam int VERIFY_WINDOW_NS = 1000;
  localparam int VERIFY_CYCLES = (VERIFY_WINDOW_NS * SYS_CLK_MHZ) / 1000;
  localparam int VERIFY_CNT_W = 12;

  // verification timer states
  typedef enum logic [2:0] {
    V_OFF = 3'b001,
    V_WATCH = 3'b010,
    V_FAILED = 3'b100
  } verify_state_t;

  // counter bit that carries a divide by 2^(tap+1); codes above 4 give /64
  function automatic logic [2:0] pwm_tap(input logic [2:0] sel);
    pwm_tap = (sel > PWM_TAP_MAX - 3'h1) ? PWM_TAP_MAX : sel;
  endfunction : pwm_tap

endpackage : clk_ctrl_pkg

//--- design/pll_and_pwm_clock_control.sv
// pll controls, pwm predivider and pll verification timer behind apb
`timescale 1ns/1ps
module pll_and_pwm_clock_control
  import clk_ctrl_pkg::*;
#(
  parameter int VERIFY_LIMIT = VERIFY_CYCLES
) (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic PLL_ALIVE_IN,
  output logic PLL_POWER_DOWN_OUT,
  output logic PLL_OUTPUT_ENABLE_N_OUT,
  output logic BYPASS_OUT,
  output logic [1:0] OSC_SOURCE_SEL_OUT,
  output logic ADC_USABLE_OUT,
  output logic PWM_CLK_OUT,
  output logic IRQ_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  // configuration fields
  logic [2:0] pwm_predivider_sel;
  logic [2:0] reserved_keep;
  logic pll_power_down;
  logic pll_output_enable_n;
  logic bypass;
  logic pll_verify_enable;
  logic [1:0] oscillator_source_sel;

  // interrupt state
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_events;

  // bus decode
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic hit_config;
  logic hit_status;
  logic hit_mask;
  logic hit_state;
  logic addr_mapped;

  // verification timer
  verify_state_t verify_state;
  verify_state_t next_verify_state;
  logic [VERIFY_CNT_W-1:0] verify_cnt;
  logic verify_expired;
  logic fail_pulse;
  logic recover_pulse;

  // pwm divider view
  logic [2:0] pwm_active_sel;
  logic pll_running;

  // read assembly
  logic [31:0] config_word;
  logic [31:0] state_word;
  logic [31:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  // zero-wait slave: every access completes in its first access cycle
  assign setup_phase = PSEL_IN & ~PENABLE_IN;
  assign access_phase = PSEL_IN & PENABLE_IN;
  assign wr_access = access_phase & PWRITE_IN;

  // full-width compare so aliases of the registers do not exist
  assign hit_config = (PADDR_IN == RUN_MODE_CLOCK_CONFIG_OFFSET);
  assign hit_status = (PADDR_IN == IRQ_STATUS_OFFSET);
  assign hit_mask = (PADDR_IN == IRQ_MASK_OFFSET);
  assign hit_state = (PADDR_IN == CLOCK_STATE_OFFSET);
  assign addr_mapped = hit_config | hit_status | hit_mask | hit_state;

  // handshake outputs are combinational
  assign PREADY_OUT = access_phase;
  assign PSLVERR_OUT = access_phase & ~addr_mapped;

  ////////////////////////////////////////////////////////////////////////////
  // configuration register fields

  // pwm predivider field
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      pwm_predivider_sel <= PWM_DIV_RESET;
    end else if (wr_access && hit_config) begin
      pwm_predivider_sel <= PWDATA_IN[PWM_DIV_MSB:PWM_DIV_LSB];
    end
  end

  // reserved bits hold whatever was written; their value has no meaning,
  // but a read-modify-write by software gets back what it stored
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      reserved_keep <= RSVD_RESET;
    end else if (wr_access && hit_config) begin
      reserved_keep <= PWDATA_IN[RSVD_MSB:RSVD_LSB];
    end
  end

  // pll power-down bit, powered down out of reset
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      pll_power_down <= PWR_DOWN_RESET;
    end else if (wr_access && hit_config) begin
      pll_power_down <= PWDATA_IN[PWR_DOWN_BIT];
    end
  end

  // pll output driver enable, active low, disabled out of reset
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      pll_output_enable_n <= OUT_EN_N_RESET;
    end else if (wr_access && hit_config) begin
      pll_output_enable_n <= PWDATA_IN[OUT_EN_N_BIT];
    end
  end

  // bypass select, oscillator drives the system out of reset
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      bypass <= BYPASS_RESET;
    end else if (wr_access && hit_config) begin
      bypass <= PWDATA_IN[BYPASS_BIT];
    end
  end

  // verification enable
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      pll_verify_enable <= VERIFY_RESET;
    end else if (wr_access && hit_config) begin
      pll_verify_enable <= PWDATA_IN[VERIFY_BIT];
    end
  end

  // oscillator source; the reserved code is refused and the old source
  // kept, so the clock tree never sees an undefined mux select
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      oscillator_source_sel <= OSC_RESET;
    end else if (wr_access && hit_config &&
                 PWDATA_IN[OSC_MSB:OSC_LSB] != OSC_RESERVED) begin
      oscillator_source_sel <= PWDATA_IN[OSC_MSB:OSC_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the pll macro and clock tree

  // pll only runs with both power-down and output disable cleared; the
  // block just reports it, sequencing the two bits is up to software
  assign pll_running = ~pll_power_down & ~pll_output_enable_n;

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      PLL_POWER_DOWN_OUT <= PWR_DOWN_RESET;
      PLL_OUTPUT_ENABLE_N_OUT <= OUT_EN_N_RESET;
    end else begin
      PLL_POWER_DOWN_OUT <= pll_power_down;
      PLL_OUTPUT_ENABLE_N_OUT <= pll_output_enable_n;
    end
  end

  // clock source selects; the glitch-free switch lives in the clock tree
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      BYPASS_OUT <= BYPASS_RESET;
      OSC_SOURCE_SEL_OUT <= OSC_RESET;
    end else begin
      BYPASS_OUT <= bypass;
      OSC_SOURCE_SEL_OUT <= oscillator_source_sel;
    end
  end

  // converter needs the pll path; this only informs, it does not block
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      ADC_USABLE_OUT <= ~BYPASS_RESET;
    end else begin
      ADC_USABLE_OUT <= ~bypass;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm timing clock

  pwm_clock_divider #(
    .CNT_W(PWM_CNT_W)
  ) u_pwm_div (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .sel_in(pwm_predivider_sel),
    .pwm_clk_out(PWM_CLK_OUT),
    .active_sel_out(pwm_active_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pll verification timer

  // the pll macro pulses PLL_ALIVE_IN while it oscillates; a silence
  // that reaches the limit counts as a failed pll
  assign verify_expired =
    (verify_cnt >= VERIFY_CNT_W'(VERIFY_LIMIT - 1)) & ~PLL_ALIVE_IN;

  // state transitions
  always_comb begin
    next_verify_state = verify_state;
    case (verify_state)
      V_OFF: begin
        if (pll_verify_enable) begin
          next_verify_state = V_WATCH;
        end
      end
      V_WATCH: begin
        if (!pll_verify_enable) begin
          next_verify_state = V_OFF;
        end else if (verify_expired) begin
          next_verify_state = V_FAILED;
        end
      end
      V_FAILED: begin
        if (!pll_verify_enable) begin
          next_verify_state = V_OFF;
        end else if (PLL_ALIVE_IN) begin
          next_verify_state = V_WATCH;
        end
      end
      default: begin
        next_verify_state = V_OFF;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      verify_state <= V_OFF;
    end else begin
      verify_state <= next_verify_state;
    end
  end

  // silence counter, held at zero whenever the timer is not watching
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      verify_cnt <= '0;
    end else if (verify_state != V_WATCH || !pll_verify_enable ||
                 PLL_ALIVE_IN) begin
      verify_cnt <= '0;
    end else if (!verify_expired) begin
      verify_cnt <= verify_cnt + VERIFY_CNT_W'(1);
    end
  end

  // one event per failure and per recovery
  assign fail_pulse = (verify_state == V_WATCH) & pll_verify_enable &
                      verify_expired;
  assign recover_pulse = (verify_state == V_FAILED) & pll_verify_enable &
                         PLL_ALIVE_IN;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  always_comb begin
    irq_events = '0;
    irq_events[IRQ_PLL_FAIL_BIT] = fail_pulse;
    irq_events[IRQ_PLL_RECOVER_BIT] = recover_pulse;
  end

  // write one to clear; a new event in the same cycle wins over the clear
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      irq_status <= IRQ_RESET;
    end else if (wr_access && hit_status) begin
      irq_status <= (irq_status & ~PWDATA_IN[IRQ_W-1:0]) | irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      irq_mask <= IRQ_RESET;
    end else if (wr_access && hit_mask) begin
      irq_mask <= PWDATA_IN[IRQ_W-1:0];
    end
  end

  // level interrupt, no pulse stretching needed since status is sticky
  assign IRQ_OUT = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb begin
    config_word = '0;
    config_word[PWM_DIV_MSB:PWM_DIV_LSB] = pwm_predivider_sel;
    config_word[RSVD_MSB:RSVD_LSB] = reserved_keep;
    config_word[PWR_DOWN_BIT] = pll_power_down;
    config_word[OUT_EN_N_BIT] = pll_output_enable_n;
    config_word[BYPASS_BIT] = bypass;
    config_word[VERIFY_BIT] = pll_verify_enable;
    config_word[OSC_MSB:OSC_LSB] = oscillator_source_sel;
  end

  // live state word; the active pwm divisor lags a write until the wrap
  always_comb begin
    state_word = '0;
    state_word[STATE_PLL_RUNNING] = pll_running;
    state_word[STATE_VERIFY_ACTIVE] = (verify_state == V_WATCH);
    state_word[STATE_PLL_FAILED] = (verify_state == V_FAILED);
    state_word[STATE_ADC_USABLE] = ~bypass;
    state_word[PWM_DIV_MSB:PWM_DIV_LSB] = pwm_active_sel;
  end

  always_comb begin
    if (hit_config) begin
      next_rdata = config_word;
    end else if (hit_status) begin
      next_rdata = {{(32-IRQ_W){1'b0}}, irq_status};
    end else if (hit_mask) begin
      next_rdata = {{(32-IRQ_W){1'b0}}, irq_mask};
    end else if (hit_state) begin
      next_rdata = state_word;
    end else begin
      next_rdata = UNMAPPED_READ;
    end
  end

  // read data is captured in the setup cycle and stands through access
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      PRDATA_OUT <= '0;
    end else if (setup_phase && !PWRITE_IN) begin
      PRDATA_OUT <= next_rdata;
    end
  end

endmodule : pll_and_pwm_clock_control

//--- design/pwm_clock_divider.sv
// glitch-free power-of-two divider for the pwm timing clock
`timescale 1ns/1ps
module pwm_clock_divider
  import clk_ctrl_pkg::*;
#(
  parameter int CNT_W = PWM_CNT_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] sel_in,
  output logic pwm_clk_out,
  output logic [2:0] active_sel_out
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic at_wrap;

  // free-running count, so every divided edge sits on a system edge
  assign next_cnt = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
  assign at_wrap = &cnt;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // a new divisor is only taken at the full wrap, where all taps are low,
  // so the switch can never cut a high or low phase short
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      active_sel_out <= PWM_DIV_RESET;
    end else if (at_wrap) begin
      active_sel_out <= sel_in;
    end
  end

  // registered tap: rising edges coincide with system rising edges
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pwm_clk_out <= 1'b0;
    end else begin
      pwm_clk_out <= next_cnt[pwm_tap(active_sel_out)];
    end
  end

endmodule : pwm_clock_divider

//--- verification/pll_and_pwm_clock_control_checker.sv
// port-level assertions for the pll and pwm clock control block
`timescale 1ns/1ps
module clock_control_checker
  import clk_ctrl_pkg::*;
#(
  parameter int VERIFY_LIMIT = VERIFY_CYCLES
) (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic PLL_ALIVE_IN,
  input wire logic PLL_POWER_DOWN_OUT,
  input wire logic PLL_OUTPUT_ENABLE_N_OUT,
  input wire logic BYPASS_OUT,
  input wire logic [1:0] OSC_SOURCE_SEL_OUT,
  input wire logic ADC_USABLE_OUT,
  input wire logic PWM_CLK_OUT,
  input wire logic IRQ_OUT
);
  logic cfg_wr;
  logic mask_wr;
  logic verify_on;
  logic [5:0] hi_cnt;
  int silent;
  assign cfg_wr = PSEL_IN && PENABLE_IN && PWRITE_IN &&
    PADDR_IN == RUN_MODE_CLOCK_CONFIG_OFFSET;
  assign mask_wr = PSEL_IN && PENABLE_IN && PWRITE_IN &&
    PADDR_IN == IRQ_MASK_OFFSET;
  // shadow of the verify bit, since the checker sees no registers
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) verify_on <= 1'b0;
    else if (cfg_wr) verify_on <= PWDATA_IN[VERIFY_BIT];
  end
  // cycles of pll silence while watching; saturates to stay bounded
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || !verify_on || PLL_ALIVE_IN) silent <= 0;
    else if (silent < 1000) silent <= silent + 1;
  end
  // length of the current high phase of the pwm clock
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || !PWM_CLK_OUT) hi_cnt <= 6'h00;
    else hi_cnt <= hi_cnt + 6'h01;
  end
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  ////////////////////////////////////////////////////////////////////////
  reset_state_a: assert property ($fell(RST_IN) |->
    PLL_POWER_DOWN_OUT && PLL_OUTPUT_ENABLE_N_OUT && BYPASS_OUT &&
    OSC_SOURCE_SEL_OUT == OSC_RESET && !IRQ_OUT)
    else $error("outputs not at reset state");
  // pins are a copy of the field flops, so a write shows two edges later
  power_down_copy_a: assert property (cfg_wr |=> ##1
    PLL_POWER_DOWN_OUT == $past(PWDATA_IN[PWR_DOWN_BIT], 2))
    else $error("power down does not follow write");
  out_gate_copy_a: assert property (cfg_wr |=> ##1
    PLL_OUTPUT_ENABLE_N_OUT == $past(PWDATA_IN[OUT_EN_N_BIT], 2))
    else $error("output gate does not follow write");
  bypass_copy_a: assert property (cfg_wr |=> ##1
    BYPASS_OUT == $past(PWDATA_IN[BYPASS_BIT], 2))
    else $error("bypass does not follow write");
  adc_vs_bypass_a: assert property (ADC_USABLE_OUT != BYPASS_OUT)
    else $error("converter usable while bypassed");
  osc_copy_a: assert property (cfg_wr &&
    PWDATA_IN[OSC_MSB:OSC_LSB] != OSC_RESERVED |=> ##1
    OSC_SOURCE_SEL_OUT == $past(PWDATA_IN[OSC_MSB:OSC_LSB], 2))
    else $error("oscillator select does not follow write");
  osc_reserved_a: assert property (cfg_wr &&
    PWDATA_IN[OSC_MSB:OSC_LSB] == OSC_RESERVED |=>
    $stable(OSC_SOURCE_SEL_OUT))
    else $error("reserved oscillator code taken");
  pwm_half_a: assert property ($fell(PWM_CLK_OUT) |->
    hi_cnt inside {6'd1, 6'd2, 6'd4, 6'd8, 6'd16, 6'd32})
    else $error("pwm high phase not a power of two");
  verify_late_a: assert property ($rose(IRQ_OUT) &&
    !$past(mask_wr) |-> silent >= VERIFY_LIMIT - 1 ||
    $past(PLL_ALIVE_IN) || $past(PLL_ALIVE_IN, 2))
    else $error("pll failure flagged too early");
  verify_off_a: assert property ($rose(IRQ_OUT) |->
    $past(verify_on) || $past(verify_on, 2) || $past(verify_on, 3) ||
    $past(mask_wr))
    else $error("interrupt with verification off");
  cover property ($rose(IRQ_OUT));
  cover property (cfg_wr && PWDATA_IN[OSC_MSB:OSC_LSB] == OSC_RESERVED);
  cover property ($fell(PWM_CLK_OUT) && hi_cnt == 6'd32);
  cover property ($fell(BYPASS_OUT));
endmodule : clock_control_checker
bind pll_and_pwm_clock_control clock_control_checker #(
  .VERIFY_LIMIT(VERIFY_LIMIT)
) clock_control_checker_inst (
  .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .PLL_ALIVE_IN(PLL_ALIVE_IN), .PLL_POWER_DOWN_OUT(PLL_POWER_DOWN_OUT),
  .PLL_OUTPUT_ENABLE_N_OUT(PLL_OUTPUT_ENABLE_N_OUT),
  .BYPASS_OUT(BYPASS_OUT), .OSC_SOURCE_SEL_OUT(OSC_SOURCE_SEL_OUT),
  .ADC_USABLE_OUT(ADC_USABLE_OUT), .PWM_CLK_OUT(PWM_CLK_OUT),
  .IRQ_OUT(IRQ_OUT)
);

//--- verification/pll_and_pwm_clock_control_tb_top.sv
// self-checking bench for the pll and pwm clock control block
`timescale 1ns/1ps
module pll_and_pwm_clock_control_tb_top;
  import clk_ctrl_pkg::*;
  localparam int LIMIT = 8;
  logic mclk, rst, psel, penable, pwrite, pslverr, pready, alive, stall;
  logic pd, oen_n, bypass, adc, pwm, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cfg, r;
  logic [1:0] osc, os_exp;
  int miscompares, n_checks, seed, p;
  pll_and_pwm_clock_control #(.VERIFY_LIMIT(LIMIT))
    pll_and_pwm_clock_control_inst (
    .MCLK_IN(mclk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .PLL_ALIVE_IN(alive), .PLL_POWER_DOWN_OUT(pd),
    .PLL_OUTPUT_ENABLE_N_OUT(oen_n), .BYPASS_OUT(bypass),
    .OSC_SOURCE_SEL_OUT(osc), .ADC_USABLE_OUT(adc), .PWM_CLK_OUT(pwm),
    .IRQ_OUT(irq));
  pll_macro_model pll_macro_model_inst (.clk_in(mclk), .rst_in(rst),
    .power_down_in(pd), .output_enable_n_in(oen_n), .stall_in(stall),
    .alive_out(alive));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n == 20) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_pwm(input logic v);
    int k;
    k = 0;
    do begin @(posedge mclk); p++; k++; end while (pwm !== v && k < 200);
  endtask : wait_pwm
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask : cycles
  function automatic logic [31:0] pwm_div(input logic [2:0] sel);
    pwm_div = (sel > 3'h4) ? 32'd64 : (32'd2 << sel);
  endfunction : pwm_div
  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // clock and watchdog; the run needs about 1200 cycles
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    cycles(20000);
    miscompares++;
    test_done;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 1341; miscompares = 0; n_checks = 0; rst = 1'b1; stall = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0;
    cycles(8);
    rst <= 1'b0;
    apb(1'b0, RUN_MODE_CLOCK_CONFIG_OFFSET, 32'h0);
    check(rd, {12'h0, 3'h7, 3'h0, 4'hE, 4'h0, 2'h0, 4'h0});
    check({pd, oen_n, bypass, adc}, 4'hE);
    cfg = rd;
    r = $random(seed);
    apb(1'b0, 12'h07C, r);
    check({err, rd[30:0]}, 32'h80000000);
    $display("test reset done");
    // every divisor code, random oscillator codes with 11 forced once
    os_exp = OSC_RESET;
    for (int c = 0; c < 8; c++) begin
      r = $random(seed);
      cfg[PWM_DIV_MSB:PWM_DIV_LSB] = c[2:0];
      cfg[RSVD_MSB:RSVD_LSB] = r[16:14];
      cfg[OSC_MSB:OSC_LSB] = (c == 5) ? OSC_RESERVED : r[1:0];
      if (cfg[OSC_MSB:OSC_LSB] != OSC_RESERVED) os_exp = cfg[5:4];
      apb(1'b1, RUN_MODE_CLOCK_CONFIG_OFFSET, cfg);
      cycles(70);
      p = 0; wait_pwm(1'b0); wait_pwm(1'b1);
      p = 0; wait_pwm(1'b0); wait_pwm(1'b1);
      check(p, pwm_div(c[2:0]));
      check(osc, os_exp);
      apb(1'b0, RUN_MODE_CLOCK_CONFIG_OFFSET, 32'h0);
      cfg[OSC_MSB:OSC_LSB] = os_exp;
      check(rd, cfg);
    end
    $display("test pwm done");
    // run the pll with the watchdog armed, then let it die
    cfg[13:10] = 4'b0001;
    apb(1'b1, IRQ_MASK_OFFSET, 32'h3);
    apb(1'b0, IRQ_MASK_OFFSET, 32'h0);
    check(rd, 32'h3);
    apb(1'b1, RUN_MODE_CLOCK_CONFIG_OFFSET, cfg);
    cycles(2);
    check({pd, oen_n, bypass, adc}, 4'h1);
    cycles(4 * LIMIT);
    check(irq, 1'b0);
    apb(1'b0, CLOCK_STATE_OFFSET, 32'h0);
    check(rd, {12'h0, cfg[19:17], 13'h0, 4'hB});
    stall <= 1'b1;
    cycles(LIMIT - 3);
    check(irq, 1'b0);
    cycles(6);
    check(irq, 1'b1);
    apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, IRQ_STATUS_OFFSET, 32'h1);
    stall <= 1'b0;
    cycles(1);
    check(irq, 1'b0);
    cycles(6);
    apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
    check({irq, rd[30:0]}, 32'h80000002);
    apb(1'b1, IRQ_STATUS_OFFSET, 32'h3);
    $display("test verify done");
    // masked failure, then unmask
    apb(1'b1, IRQ_MASK_OFFSET, 32'h0);
    stall <= 1'b1;
    cycles(LIMIT + 6);
    check(irq, 1'b0);
    apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, IRQ_MASK_OFFSET, 32'h1);
    cycles(1);
    check(irq, 1'b1);
    apb(1'b1, IRQ_STATUS_OFFSET, 32'h3);
    // watchdog off with a dead pll raises nothing
    cfg[VERIFY_BIT] = 1'b0;
    apb(1'b1, RUN_MODE_CLOCK_CONFIG_OFFSET, cfg);
    cycles(3 * LIMIT);
    apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
    check({irq, rd[30:0]}, 32'h0);
    $display("test irq done");
    test_done;
  end
endmodule : pll_and_pwm_clock_control_tb_top

//--- verification/pll_macro_model.sv
// behavioural model of the analog pll macro seen from the clock block
`timescale 1ns/1ps
module pll_macro_model #(
  parameter int ALIVE_GAP = 3
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic power_down_in,
  input wire logic output_enable_n_in,
  input wire logic stall_in,
  output logic alive_out
);
  int cnt;
  // pulses only while powered and driving out; stall mimics a dead pll
  always_ff @(posedge clk_in) begin
    if (rst_in || power_down_in || output_enable_n_in || stall_in) begin
      cnt <= 0;
      alive_out <= 1'b0;
    end else begin
      cnt <= (cnt == ALIVE_GAP - 1) ? 0 : cnt + 1;
      alive_out <= (cnt == ALIVE_GAP - 1);
    end
  end
endmodule : pll_macro_model
